// ### shared/flash_host_pkg.sv
package flash_host_pkg;

	// ****************************************************************
	// Clock and bus-cycle timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_ADDR_SETUP_NS = 50;
	localparam int T_WE_LOW_NS = 100;
	localparam int T_RD_ACCESS_NS = 120;
	localparam int T_RECOVER_NS = 50;
	localparam int ADDR_SETUP_CYC =
		(T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_ACCESS_CYC =
		(T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Longest time the array may take to halt an erase after suspend.
	localparam int SUSPEND_MAX_US = 35;
	localparam int SUSPEND_WAIT_CYC =
		(SUSPEND_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// Flash command words and addresses
	// ****************************************************************
	localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
	localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;
	localparam logic [11:0] PROTECT_OFS = 12'h002;
	localparam logic [11:0] LOCK_OFS = 12'h003;
	localparam int SECTOR_LSB = 12;
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYPASS_EXIT = 8'h90;
	localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_SECURED = 8'h88;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;

	// Status bit positions in data read back from the flash.
	localparam int POLLING_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERROR_STATUS_BIT = 5;
	localparam int SECTOR_TOGGLE_BIT = 2;

	// ****************************************************************
	// Controller register map
	// ****************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_TOGGLED = 1;
	localparam int ST_SECTOR_TOGGLED = 2;
	localparam int ST_ERROR = 3;
	localparam int ST_SUSPENDED = 4;
	localparam int ST_BYPASS = 5;
	localparam int ST_POLLING = 6;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [3:0] {
		OP_READ,
		OP_RESET,
		OP_SUSPEND,
		OP_RESUME,
		OP_PROGRAM,
		OP_BYPASS_ENTER,
		OP_BYPASS_PROGRAM,
		OP_BYPASS_EXIT,
		OP_PROTECT_VERIFY,
		OP_LOCK_READ,
		OP_SECURED_ENTER,
		OP_SECTOR_ERASE,
		OP_SECTOR_ADD,
		OP_CHIP_ERASE
	} op_t;
	localparam int OP_COUNT = 14;

endpackage

// ### design/flash_bus_cycle.sv
`timescale 1ns/1ns
module flash_bus_cycle #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 16
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic is_read_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic [DATA_W-1:0] dq_in,
	output logic done_out,
	output logic [DATA_W-1:0] rdata_out,
	output logic [ADDR_W-1:0] addr_out,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_out,
	output logic ce_n_out,
	output logic we_n_out,
	output logic oe_n_out
);

	typedef enum {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_RECOVER} cyc_state_t;

	if (flash_host_pkg::ADDR_SETUP_CYC > 15 || flash_host_pkg::WE_LOW_CYC > 15 ||
		flash_host_pkg::RD_ACCESS_CYC > 15 || flash_host_pkg::RECOVER_CYC > 15)
	begin : g_bad_timing
		$error("flash_bus_cycle: timing count exceeds counter width");
	end

	cyc_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic rd_reg, rd_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] dq_reg, dq_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic oe_drv_reg, oe_drv_next;
	logic ce_n_reg, ce_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;

	// ****************************************************************
	// Cycle sequencing
	// ****************************************************************
	// The write pulse ends one cycle before chip select and data drive are released,
	// so the flash latches data on the rising strobe with hold margin.
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		rd_next = rd_reg;
		addr_next = addr_reg;
		dq_next = dq_reg;
		rdata_next = rdata_reg;
		oe_drv_next = oe_drv_reg;
		ce_n_next = ce_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		case (state_reg)
			C_IDLE:
			begin
				if (start_in)
				begin
					rd_next = is_read_in;
					addr_next = addr_in;
					dq_next = data_in;
					oe_drv_next = !is_read_in;
					ce_n_next = 1'b0;
					cnt_next = 4'(flash_host_pkg::ADDR_SETUP_CYC - 1);
					state_next = C_SETUP;
				end
			end
			C_SETUP:
			begin
				if (cnt_reg == 4'h0)
				begin
					we_n_next = rd_reg;
					oe_n_next = !rd_reg;
					cnt_next = rd_reg ? 4'(flash_host_pkg::RD_ACCESS_CYC - 1) :
						4'(flash_host_pkg::WE_LOW_CYC - 1);
					state_next = C_PULSE;
				end
				else
					cnt_next = cnt_reg - 4'h1;
			end
			C_PULSE:
			begin
				if (cnt_reg == 4'h0)
				begin
					if (rd_reg)
						rdata_next = dq_in;
					we_n_next = 1'b1;
					oe_n_next = 1'b1;
					state_next = C_HOLD;
				end
				else
					cnt_next = cnt_reg - 4'h1;
			end
			C_HOLD:
			begin
				ce_n_next = 1'b1;
				oe_drv_next = 1'b0;
				cnt_next = 4'(flash_host_pkg::RECOVER_CYC - 1);
				state_next = C_RECOVER;
			end
			C_RECOVER:
			begin
				if (cnt_reg == 4'h0)
					state_next = C_IDLE;
				else
					cnt_next = cnt_reg - 4'h1;
			end
			default:
				state_next = C_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_reg <= C_IDLE;
			cnt_reg <= 4'h0;
			rd_reg <= 1'b0;
			addr_reg <= '0;
			dq_reg <= '0;
			rdata_reg <= '0;
			oe_drv_reg <= 1'b0;
			ce_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			rd_reg <= rd_next;
			addr_reg <= addr_next;
			dq_reg <= dq_next;
			rdata_reg <= rdata_next;
			oe_drv_reg <= oe_drv_next;
			ce_n_reg <= ce_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign done_out = (state_reg == C_RECOVER) && (cnt_reg == 4'h0);
	assign rdata_out = rdata_reg;
	assign addr_out = addr_reg;
	assign dq_out = dq_reg;
	assign dq_oe_out = oe_drv_reg;
	assign ce_n_out = ce_n_reg;
	assign we_n_out = we_n_reg;
	assign oe_n_out = oe_n_reg;

endmodule

// ### design/flash_host_ctrl.sv
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
// Overview of operation
// - Suspend is one write of B0; address driven as zero.
// - Resume is one write of 30 at any address; repeats are harmless.
// - Program is 555/AA, 2AA/55, 555/A0, then target address and data.
// - Bypass entry is unlock then 555/20; bypass program is A0 then data.
// - Bypass exit is 90 then F0 at any address.
// - Secured region entry is the two unlocks then 555/88.
// - Reset is a single write of F0 to return to array reads.
module flash_host_ctrl #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 16
) (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic [ADDR_W-1:0] FLASH_ADDR_OUT,
	input wire logic [DATA_W-1:0] FLASH_DQ_IN,
	output logic [DATA_W-1:0] FLASH_DQ_OUT,
	output logic FLASH_DQ_OE_OUT,
	output logic FLASH_CE_N_OUT,
	output logic FLASH_WE_N_OUT,
	output logic FLASH_OE_N_OUT
);

	typedef enum {S_IDLE, S_RUN, S_WAIT} state_t;
	localparam int WAIT_W = $clog2(flash_host_pkg::SUSPEND_WAIT_CYC + 1);

	if (ADDR_W <= flash_host_pkg::SECTOR_LSB || ADDR_W > 32 || DATA_W < 8 ||
		DATA_W > 32)
	begin : g_bad_width
		$error("flash_host_ctrl: unsupported address or data width");
	end

	state_t state_reg, state_next;
	flash_host_pkg::op_t op_reg, op_next;
	logic [2:0] step_reg, step_next;
	logic start_reg, start_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic tog_reg, tog_next;
	logic stog_reg, stog_next;
	logic susp_reg, susp_next;
	logic byp_reg, byp_next;
	logic [WAIT_W-1:0] wait_reg, wait_next;
	logic [31:0] prdata_reg, prdata_next;

	logic st_read, st_last, unlocked, erasing;
	logic [ADDR_W-1:0] st_addr;
	logic [DATA_W-1:0] st_data;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic [31:0] status_word, rd_mux;
	logic mapped, apb_setup, wr_access, idle, op_ok;
	logic [3:0] new_code;

	// ****************************************************************
	// Command sequence table
	// ****************************************************************
	// Command words carry zero in the upper byte.
	always_comb
	begin
		st_addr = addr_reg;
		st_data = wdata_reg;
		st_read = 1'b0;
		st_last = 1'b0;
		unlocked = !(op_reg inside {flash_host_pkg::OP_READ,
			flash_host_pkg::OP_RESET, flash_host_pkg::OP_SUSPEND,
			flash_host_pkg::OP_RESUME, flash_host_pkg::OP_BYPASS_PROGRAM,
			flash_host_pkg::OP_BYPASS_EXIT, flash_host_pkg::OP_SECTOR_ADD});
		erasing = (op_reg == flash_host_pkg::OP_SECTOR_ERASE) ||
			(op_reg == flash_host_pkg::OP_CHIP_ERASE);
		if ((unlocked && step_reg == 3'h0) || (erasing && step_reg == 3'h3))
		begin
			st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
			st_data = DATA_W'(flash_host_pkg::CMD_UNLOCK1);
		end
		else if ((unlocked && step_reg == 3'h1) || (erasing && step_reg == 3'h4))
		begin
			st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR2);
			st_data = DATA_W'(flash_host_pkg::CMD_UNLOCK2);
		end
		else
		begin
			st_last = 1'b1;
			case (op_reg)
				flash_host_pkg::OP_READ:
					st_read = 1'b1;
				flash_host_pkg::OP_RESET:
				begin
					st_addr = '0;
					st_data = DATA_W'(flash_host_pkg::CMD_RESET);
				end
				flash_host_pkg::OP_SUSPEND:
				begin
					st_addr = '0;
					st_data = DATA_W'(flash_host_pkg::CMD_SUSPEND);
				end
				flash_host_pkg::OP_RESUME:
				begin
					st_addr = '0;
					st_data = DATA_W'(flash_host_pkg::CMD_RESUME);
				end
				flash_host_pkg::OP_PROGRAM:
				begin
					if (step_reg == 3'h2)
					begin
						st_last = 1'b0;
						st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
						st_data = DATA_W'(flash_host_pkg::CMD_PROGRAM);
					end
				end
				flash_host_pkg::OP_BYPASS_ENTER:
				begin
					st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
					st_data = DATA_W'(flash_host_pkg::CMD_BYPASS);
				end
				flash_host_pkg::OP_BYPASS_PROGRAM:
				begin
					if (step_reg == 3'h0)
					begin
						st_last = 1'b0;
						st_addr = '0;
						st_data = DATA_W'(flash_host_pkg::CMD_PROGRAM);
					end
				end
				flash_host_pkg::OP_BYPASS_EXIT:
				begin
					st_addr = '0;
					st_data = DATA_W'(flash_host_pkg::CMD_RESET);
					if (step_reg == 3'h0)
					begin
						st_last = 1'b0;
						st_data = DATA_W'(flash_host_pkg::CMD_BYPASS_EXIT);
					end
				end
				flash_host_pkg::OP_PROTECT_VERIFY, flash_host_pkg::OP_LOCK_READ:
				begin
					if (step_reg == 3'h2)
					begin
						st_last = 1'b0;
						st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
						st_data = DATA_W'(flash_host_pkg::CMD_AUTOSELECT);
					end
					else if (op_reg == flash_host_pkg::OP_PROTECT_VERIFY)
					begin
						st_read = 1'b1;
						st_addr = {addr_reg[ADDR_W-1:flash_host_pkg::SECTOR_LSB],
							flash_host_pkg::PROTECT_OFS};
					end
					else
					begin
						st_read = 1'b1;
						st_addr = ADDR_W'(flash_host_pkg::LOCK_OFS);
					end
				end
				flash_host_pkg::OP_SECURED_ENTER:
				begin
					st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
					st_data = DATA_W'(flash_host_pkg::CMD_SECURED);
				end
				flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_CHIP_ERASE,
				flash_host_pkg::OP_SECTOR_ADD:
				begin
					if (step_reg == 3'h2)
					begin
						st_last = 1'b0;
						st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
						st_data = DATA_W'(flash_host_pkg::CMD_ERASE_SETUP);
					end
					else if (op_reg == flash_host_pkg::OP_CHIP_ERASE)
					begin
						st_addr = ADDR_W'(flash_host_pkg::UNLOCK_ADDR1);
						st_data = DATA_W'(flash_host_pkg::CMD_CHIP_ERASE);
					end
					else
						st_data = DATA_W'(flash_host_pkg::CMD_SECTOR_ERASE);
				end
				default:
					st_addr = addr_reg;
			endcase
		end
	end

	// ****************************************************************
	// Register access and operation control
	// ****************************************************************
	assign idle = (state_reg == S_IDLE);
	assign apb_setup = PSEL_IN && !PENABLE_IN;
	assign wr_access = PSEL_IN && PENABLE_IN && PWRITE_IN && mapped;
	assign new_code = PWDATA_IN[flash_host_pkg::CTRL_OP_LSB +: 4];
	assign op_ok = new_code < 4'(flash_host_pkg::OP_COUNT);
	assign mapped = PADDR_IN inside {flash_host_pkg::REG_CTRL,
		flash_host_pkg::REG_ADDR, flash_host_pkg::REG_WDATA,
		flash_host_pkg::REG_STATUS, flash_host_pkg::REG_RDATA};

	always_comb
	begin
		status_word = flash_host_pkg::RESET_WORD;
		status_word[flash_host_pkg::ST_BUSY] = !idle;
		status_word[flash_host_pkg::ST_TOGGLED] = tog_reg;
		status_word[flash_host_pkg::ST_SECTOR_TOGGLED] = stog_reg;
		status_word[flash_host_pkg::ST_ERROR] =
			rdata_reg[flash_host_pkg::ERROR_STATUS_BIT];
		status_word[flash_host_pkg::ST_SUSPENDED] = susp_reg;
		status_word[flash_host_pkg::ST_BYPASS] = byp_reg;
		status_word[flash_host_pkg::ST_POLLING] =
			rdata_reg[flash_host_pkg::POLLING_BIT];
		case (PADDR_IN)
			flash_host_pkg::REG_CTRL:
				rd_mux = 32'(op_reg);
			flash_host_pkg::REG_ADDR:
				rd_mux = 32'(addr_reg);
			flash_host_pkg::REG_WDATA:
				rd_mux = 32'(wdata_reg);
			flash_host_pkg::REG_STATUS:
				rd_mux = status_word;
			flash_host_pkg::REG_RDATA:
				rd_mux = 32'(rdata_reg);
			default:
				rd_mux = flash_host_pkg::RESET_WORD;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		step_next = step_reg;
		start_next = 1'b0;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		tog_next = tog_reg;
		stog_next = stog_reg;
		susp_next = susp_reg;
		byp_next = byp_reg;
		wait_next = wait_reg;
		prdata_next = apb_setup ? rd_mux : prdata_reg;
		// Operands are frozen while a sequence runs, so a late write
		// cannot tear a command apart half way.
		if (wr_access && idle && PADDR_IN == flash_host_pkg::REG_ADDR)
			addr_next = PWDATA_IN[ADDR_W-1:0];
		if (wr_access && idle && PADDR_IN == flash_host_pkg::REG_WDATA)
			wdata_next = PWDATA_IN[DATA_W-1:0];
		case (state_reg)
			S_IDLE:
			begin
				if (wr_access && PADDR_IN == flash_host_pkg::REG_CTRL && op_ok)
				begin
					op_next = flash_host_pkg::op_t'(new_code);
					step_next = 3'h0;
					start_next = 1'b1;
					state_next = S_RUN;
				end
			end
			S_RUN:
			begin
				if (cyc_done && st_read)
				begin
					rdata_next = cyc_rdata;
					tog_next = cyc_rdata[flash_host_pkg::TOGGLE_BIT] ^
						rdata_reg[flash_host_pkg::TOGGLE_BIT];
					stog_next = cyc_rdata[flash_host_pkg::SECTOR_TOGGLE_BIT] ^
						rdata_reg[flash_host_pkg::SECTOR_TOGGLE_BIT];
				end
				if (cyc_done && !st_last)
				begin
					step_next = step_reg + 3'h1;
					start_next = 1'b1;
				end
				else if (cyc_done)
				begin
					state_next = S_IDLE;
					case (op_reg)
						flash_host_pkg::OP_SUSPEND:
						begin
							susp_next = 1'b1;
							wait_next = WAIT_W'(flash_host_pkg::SUSPEND_WAIT_CYC - 1);
							state_next = S_WAIT;
						end
						flash_host_pkg::OP_RESUME:
							susp_next = 1'b0;
						flash_host_pkg::OP_BYPASS_ENTER:
							byp_next = 1'b1;
						flash_host_pkg::OP_BYPASS_EXIT, flash_host_pkg::OP_RESET:
							byp_next = 1'b0;
						default:
							byp_next = byp_reg;
					endcase
				end
			end
			S_WAIT:
			begin
				if (wait_reg == '0)
					state_next = S_IDLE;
				else
					wait_next = wait_reg - WAIT_W'(1);
			end
			default:
				state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			state_reg <= S_IDLE;
			op_reg <= flash_host_pkg::OP_READ;
			step_reg <= 3'h0;
			start_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			tog_reg <= 1'b0;
			stog_reg <= 1'b0;
			susp_reg <= 1'b0;
			byp_reg <= 1'b0;
			wait_reg <= '0;
			prdata_reg <= flash_host_pkg::RESET_WORD;
		end
		else
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			step_reg <= step_next;
			start_reg <= start_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			tog_reg <= tog_next;
			stog_reg <= stog_next;
			susp_reg <= susp_next;
			byp_reg <= byp_next;
			wait_reg <= wait_next;
			prdata_reg <= prdata_next;
		end
	end

	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

	// ****************************************************************
	// Flash pin sequencer
	// ****************************************************************
	flash_bus_cycle #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) u_cycle (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.start_in(start_reg),
		.is_read_in(st_read),
		.addr_in(st_addr),
		.data_in(st_data),
		.dq_in(FLASH_DQ_IN),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.addr_out(FLASH_ADDR_OUT),
		.dq_out(FLASH_DQ_OUT),
		.dq_oe_out(FLASH_DQ_OE_OUT),
		.ce_n_out(FLASH_CE_N_OUT),
		.we_n_out(FLASH_WE_N_OUT),
		.oe_n_out(FLASH_OE_N_OUT)
	);

endmodule

// ### test/flash_host_ctrl_asserts.sv
`timescale 1ns/1ns
module flash_host_ctrl_asserts #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 16
) (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic [ADDR_W-1:0] FLASH_ADDR_OUT,
	input wire logic [DATA_W-1:0] FLASH_DQ_OUT,
	input wire logic FLASH_DQ_OE_OUT,
	input wire logic FLASH_CE_N_OUT,
	input wire logic FLASH_WE_N_OUT,
	input wire logic FLASH_OE_N_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	a_write_drive: assert property (
		!FLASH_WE_N_OUT |-> !FLASH_CE_N_OUT && FLASH_DQ_OE_OUT && FLASH_OE_N_OUT)
		else $error("write strobe without data drive");
	a_read_float: assert property (
		!FLASH_OE_N_OUT |-> !FLASH_DQ_OE_OUT && FLASH_WE_N_OUT && !FLASH_CE_N_OUT)
		else $error("read strobe while driving");
	a_we_width: assert property (
		$fell(FLASH_WE_N_OUT) |=> !FLASH_WE_N_OUT ##1 FLASH_WE_N_OUT)
		else $error("write strobe width wrong");
	a_oe_width: assert property (
		$fell(FLASH_OE_N_OUT) |=> !FLASH_OE_N_OUT[*2] ##1 FLASH_OE_N_OUT)
		else $error("read strobe width wrong");
	a_ce_gap: assert property (
		$rose(FLASH_CE_N_OUT) |-> FLASH_CE_N_OUT[*2])
		else $error("chip select gap too short");
	// A first unlock word must always be followed by the second one.
	a_unlock_next: assert property (
		$fell(FLASH_WE_N_OUT) && FLASH_ADDR_OUT[11:0] == 12'h555
		&& FLASH_DQ_OUT[7:0] == 8'hAA |-> ##[5:9] ($fell(FLASH_WE_N_OUT)
		&& FLASH_ADDR_OUT[11:0] == 12'h2AA && FLASH_DQ_OUT[7:0] == 8'h55))
		else $error("unlock sequence broken");
	a_suspend_word: assert property (
		$fell(FLASH_WE_N_OUT) && FLASH_DQ_OUT[7:0] == 8'hB0
		|-> FLASH_ADDR_OUT == 0 && FLASH_DQ_OUT[15:8] == 8'h00)
		else $error("suspend word malformed");
	a_bad_addr: assert property (
		PSEL_IN && PENABLE_IN && !(PADDR_IN inside {8'h00, 8'h04, 8'h08,
		8'h0C, 8'h10}) |-> PSLVERR_OUT && PREADY_OUT)
		else $error("unmapped access not refused");
endmodule
bind flash_host_ctrl flash_host_ctrl_asserts #(.ADDR_W(ADDR_W),
	.DATA_W(DATA_W)) chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.FLASH_ADDR_OUT(FLASH_ADDR_OUT), .FLASH_DQ_OUT(FLASH_DQ_OUT),
	.FLASH_DQ_OE_OUT(FLASH_DQ_OE_OUT), .FLASH_CE_N_OUT(FLASH_CE_N_OUT),
	.FLASH_WE_N_OUT(FLASH_WE_N_OUT), .FLASH_OE_N_OUT(FLASH_OE_N_OUT));

// ### test/flash_model.sv
`timescale 1ns/1ns
module flash_model #(
	parameter int PROT_SEC = 2,
	parameter logic [15:0] LOCK_CODE = 16'h0089
) (
	input wire logic [18:0] addr_in,
	input wire logic [15:0] dq_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	output logic [15:0] dq_out
);
	logic [15:0] mem [logic [18:0]];
	logic [15:0] rd = 16'h0000;
	logic [15:0] pd;
	logic tg = 1'b0;
	logic [6:0] es;
	int st = 0;
	int md = 0;
	int er = 0;
	time tw;
	time tp = 0;
	// A released bus shows the inverse of the last word, never a stale copy.
	assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
	always @(posedge we_n_in)
	begin
		if (er == 1 && $time - tw > 50000)
			er = 2;
		if (!ce_n_in && $time >= tp)
		begin
			if (st == 3)
			begin
				mem[addr_in] = dq_in;
				pd = dq_in;
				tp = $time + 5000;
				st = 0;
			end
			else if (md == 2)
			begin
				if (st == 7 && dq_in[7:0] == 8'hF0)
					md = 0;
				st = dq_in[7:0] == 8'hA0 ? 3 : dq_in[7:0] == 8'h90 ? 7 : 0;
			end
			else if (dq_in[7:0] == 8'hF0)
				md = 0;
			else if (dq_in[7:0] == 8'hB0)
				er = (er == 1 || er == 2) ? 3 : er;
			else if (dq_in[7:0] == 8'h30 && st != 6)
				er = er == 3 ? 2 : er;
			else
				case (st)
				0: st = addr_in[11:0] == 12'h555 && dq_in[7:0] == 8'hAA;
				1: st = addr_in[11:0] == 12'h2AA && dq_in[7:0] == 8'h55 ? 2 : 0;
				4: st = dq_in[7:0] == 8'hAA ? 5 : 0;
				5: st = dq_in[7:0] == 8'h55 ? 6 : 0;
				2:
				begin
					md = dq_in[7:0] == 8'h20 ? 2 : dq_in[7:0] == 8'h90 ? 1 : md;
					st = dq_in[7:0] == 8'hA0 ? 3 : dq_in[7:0] == 8'h80 ? 4 : 0;
				end
				default:
				begin
					er = dq_in[7:0] == 8'h10 ? 5 : 1;
					es = addr_in[18:12];
					tw = $time;
					st = 0;
				end
				endcase
		end
	end
	always @(negedge oe_n_in)
	begin
		if ($time < tp)
			rd = {8'h00, ~pd[7], tg, 6'h00};
		else if (md == 1)
			rd = addr_in[7:0] == 8'h02 ? 16'(addr_in[18:12] == PROT_SEC) : LOCK_CODE;
		else if (er == 5 || (er != 0 && addr_in[18:12] == es))
			rd = {8'h00, er == 3, tg && er != 3, 3'h0, tg, 2'h0};
		else
			rd = mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
		tg = !tg;
	end
endmodule

// ### test/flash_host_ctrl_tb_top.sv
`timescale 1ns/1ns
module flash_host_ctrl_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic [18:0] fa;
	logic [15:0] dq_ctl;
	logic [15:0] dq_mem;
	logic oe;
	logic ce_n;
	logic we_n;
	logic oe_n;
	wire [15:0] dq_bus = oe ? dq_ctl : dq_mem;
	int fail_count = 0;
	int check_count = 0;
	flash_host_ctrl uut (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .FLASH_ADDR_OUT(fa), .FLASH_DQ_IN(dq_bus),
		.FLASH_DQ_OUT(dq_ctl), .FLASH_DQ_OE_OUT(oe), .FLASH_CE_N_OUT(ce_n),
		.FLASH_WE_N_OUT(we_n), .FLASH_OE_N_OUT(oe_n));
	flash_model mdl (.addr_in(fa), .dq_in(dq_bus), .ce_n_in(ce_n),
		.we_n_in(we_n), .oe_n_in(oe_n), .dq_out(dq_mem));
	initial
		forever #25 clk = ~clk;
	task automatic conclude;
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic sts;
		apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
	endtask
	// Busy is polled, so the long suspend hold needs no fixed wait here;
	// a hang is left to the watchdog.
	task automatic run(input flash_host_pkg::op_t op, input logic [18:0] a,
		input logic [15:0] d);
		apb(1'b1, flash_host_pkg::REG_ADDR, {13'h0000, a});
		apb(1'b1, flash_host_pkg::REG_WDATA, {16'h0000, d});
		apb(1'b1, flash_host_pkg::REG_CTRL, {28'h0000000, op});
		sts();
		while (rd[0] !== 1'b0)
			sts();
	endtask
	task automatic rdf(input logic [18:0] a);
		run(flash_host_pkg::OP_READ, a, 16'h0000);
		apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		$display("Error %0t: timeout", $time);
		fail_count++;
		conclude();
	end
	initial
	begin
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		sts();
		chk(rd, flash_host_pkg::RESET_WORD);
		apb(1'b0, 8'h14, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		run(flash_host_pkg::OP_PROGRAM, 19'h00010, 16'h1234);
		rdf(19'h00010);
		chk(32'(rd[7]), 32'h1);
		repeat (100) @(posedge clk);
		rdf(19'h00010);
		chk(rd, 32'h1234);
		run(flash_host_pkg::OP_BYPASS_ENTER, 19'h0, 16'h0);
		sts();
		chk(32'(rd[5]), 32'h1);
		run(flash_host_pkg::OP_BYPASS_PROGRAM, 19'h00020, 16'h5A5A);
		repeat (100) @(posedge clk);
		run(flash_host_pkg::OP_BYPASS_EXIT, 19'h0, 16'h0);
		rdf(19'h00020);
		chk(rd, 32'h5A5A);
		for (int s = 2; s < 4; s++)
		begin
			run(flash_host_pkg::OP_PROTECT_VERIFY, {s[6:0], 12'h000}, 16'h0);
			apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
			chk(rd, 32'(s == 2));
			run(flash_host_pkg::OP_RESET, 19'h0, 16'h0);
		end
		run(flash_host_pkg::OP_SECURED_ENTER, 19'h0, 16'h0);
		run(flash_host_pkg::OP_RESET, 19'h0, 16'h0);
		run(flash_host_pkg::OP_SECTOR_ERASE, 19'h01000, 16'h0);
		run(flash_host_pkg::OP_SUSPEND, 19'h0, 16'h0);
		sts();
		chk(32'(rd[4]), 32'h1);
		rdf(19'h01004);
		chk(32'(rd[7:6]), 32'h2);
		rdf(19'h01004);
		sts();
		chk(32'(rd[2:1]), 32'h2);
		rdf(19'h00010);
		chk(rd, 32'h1234);
		run(flash_host_pkg::OP_LOCK_READ, 19'h01000, 16'h0);
		apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
		chk(rd, 32'h0089);
		run(flash_host_pkg::OP_PROTECT_VERIFY, 19'h01000, 16'h0);
		apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
		chk(rd, 32'h0);
		run(flash_host_pkg::OP_RESET, 19'h0, 16'h0);
		rdf(19'h01004);
		chk(32'(rd[7]), 32'h1);
		run(flash_host_pkg::OP_RESUME, 19'h0, 16'h0);
		run(flash_host_pkg::OP_RESUME, 19'h0, 16'h0);
		rdf(19'h01004);
		chk(32'(rd[7]), 32'h0);
		rdf(19'h01004);
		sts();
		chk(32'(rd[4:1]), 32'h3);
		run(flash_host_pkg::OP_SUSPEND, 19'h0, 16'h0);
		rdf(19'h01004);
		chk(32'(rd[7]), 32'h1);
		run(flash_host_pkg::OP_CHIP_ERASE, 19'h0, 16'h0);
		run(flash_host_pkg::OP_SUSPEND, 19'h0, 16'h0);
		rdf(19'h00010);
		chk(32'({rd[15:7], rd[5:3], rd[1:0]}), 32'h0);
		conclude();
	end
endmodule
